// ### rtl/pcr_regs.svh
/*
  offsets, field positions, reset values and timing counts shared by
  both ends of the analog control reconfiguration link.
  assumes inclusion by bare name, inside or outside a module.
*/
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// per-channel field widths
`define PCR_VOD_W 3
`define PCR_PRE_W 5
`define PCR_DCG_W 2
`define PCR_EQ_W 4

// direction select codes
`define PCR_DIR_TX_ONLY 2'h2
`define PCR_DIR_RX_ONLY 2'h1
`define PCR_DIR_RST 2'h3

// default channel count and cycles spent on each channel
`define PCR_N_CH 4
`define PCR_STEP_CYCLES 4

// requester register offsets (byte addresses)
`define PCR_OFS_CTRL 12'h000
`define PCR_OFS_STAT 12'h004
`define PCR_OFS_DIR 12'h008
`define PCR_OFS_WVOD 12'h00C
`define PCR_OFS_WPRE 12'h010
`define PCR_OFS_WDCG 12'h014
`define PCR_OFS_WEQ 12'h018
`define PCR_OFS_RVOD 12'h01C
`define PCR_OFS_RPRE 12'h020
`define PCR_OFS_RDCG 12'h024
`define PCR_OFS_REQ 12'h028

// control and status bit positions
`define PCR_CTRL_WR_BIT 0
`define PCR_CTRL_RD_BIT 1
`define PCR_STAT_BUSY_BIT 0
`define PCR_STAT_DV_BIT 1
`define PCR_STAT_PEND_BIT 2

`endif

// ### rtl/pcr_pkg.sv
/*
  types shared by the reconfiguration controller and its requester.
  assumes nothing of its surroundings.
*/
package pcr_pkg;

  typedef enum logic [1:0] {PCR_IDLE, PCR_WRITE, PCR_READ} pcr_dev_st_t;

  typedef enum logic [1:0] {
    PCR_H_IDLE,
    PCR_H_PEND,
    PCR_H_ISSUE,
    PCR_H_WAIT
  } pcr_req_st_t;

  typedef enum logic {PCR_OP_WR, PCR_OP_RD} pcr_op_t;

endpackage

// ### rtl/pcr_link_if.sv
/*
  link between the reconfiguration controller and its requester.
  assumes both ends run on the same clock and use the same parameters.
*/
`timescale 1ns/1ps
`include "pcr_regs.svh"

interface pcr_link_if #(
  parameter int N_CH = `PCR_N_CH,
  parameter bit SHARED = 1'b1
) ();
  localparam int M = SHARED ? 1 : N_CH;

  logic write_all;
  logic read;
  logic [1:0] dir_sel;
  logic [`PCR_VOD_W*M-1:0] vod;
  logic [`PCR_PRE_W*M-1:0] preemp;
  logic [`PCR_DCG_W*M-1:0] dcgain;
  logic [`PCR_EQ_W*M-1:0] eqctrl;
  logic busy;
  logic data_valid;
  logic [`PCR_VOD_W*N_CH-1:0] vod_out;
  logic [`PCR_PRE_W*N_CH-1:0] preemp_out;
  logic [`PCR_DCG_W*N_CH-1:0] dcgain_out;
  logic [`PCR_EQ_W*N_CH-1:0] eqctrl_out;

  modport dev (
    input write_all, read, dir_sel, vod, preemp, dcgain, eqctrl,
    output busy, data_valid, vod_out, preemp_out, dcgain_out, eqctrl_out
  );

  modport req (
    output write_all, read, dir_sel, vod, preemp, dcgain, eqctrl,
    input busy, data_valid, vod_out, preemp_out, dcgain_out, eqctrl_out
  );
endinterface

// ### rtl/pcr_req_end.sv
/*
  requester end: apb slave whose registers order writes and reads of
  the analog channel settings and show the controller's status.
  assumes a controller end on the same link and clock.
*/
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_req_end
  import pcr_pkg::*;
#(
  parameter int N_CH = `PCR_N_CH,
  parameter bit SHARED = 1'b1
) (
  input wire logic pclk, // 200 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic [11:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  pcr_link_if.req lnk // link to the controller
);

  localparam int M = SHARED ? 1 : N_CH;
  localparam int VW = `PCR_VOD_W * M;
  localparam int PW = `PCR_PRE_W * M;
  localparam int DW = `PCR_DCG_W * M;
  localparam int EW = `PCR_EQ_W * M;

  initial begin
    if (N_CH < 1 || `PCR_PRE_W * N_CH > 32) begin
      $error("pcr_req_end: N_CH must be 1 to 6");
    end
  end

  typedef struct packed {
    pcr_req_st_t st;
    pcr_op_t op;
    logic [1:0] dir;
    logic [VW-1:0] vod;
    logic [PW-1:0] pre;
    logic [DW-1:0] dcg;
    logic [EW-1:0] eq;
    logic [31:0] rdata;
    logic err;
  } pcr_req_state_t;

  pcr_req_state_t q, n;

  function automatic logic mapped(input logic [11:0] a);
    return a <= `PCR_OFS_REQ && a[1:0] == 2'h0;
  endfunction

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    logic setup;
    logic access;
    setup = psel && !penable;
    access = psel && penable;
    n = q;
    if (setup) begin
      n.err = !mapped(paddr);
      n.rdata = 32'h0000_0000;
      case (paddr)
        `PCR_OFS_STAT: begin
          n.rdata[`PCR_STAT_BUSY_BIT] = lnk.busy;
          n.rdata[`PCR_STAT_DV_BIT] = lnk.data_valid;
          n.rdata[`PCR_STAT_PEND_BIT] = q.st != PCR_H_IDLE;
        end
        `PCR_OFS_DIR: n.rdata[1:0] = q.dir;
        `PCR_OFS_WVOD: n.rdata[VW-1:0] = q.vod;
        `PCR_OFS_WPRE: n.rdata[PW-1:0] = q.pre;
        `PCR_OFS_WDCG: n.rdata[DW-1:0] = q.dcg;
        `PCR_OFS_WEQ: n.rdata[EW-1:0] = q.eq;
        // read-back words feed unchanged channels into a rewrite
        `PCR_OFS_RVOD: n.rdata[`PCR_VOD_W*N_CH-1:0] = lnk.vod_out;
        `PCR_OFS_RPRE: n.rdata[`PCR_PRE_W*N_CH-1:0] = lnk.preemp_out;
        `PCR_OFS_RDCG: n.rdata[`PCR_DCG_W*N_CH-1:0] = lnk.dcgain_out;
        `PCR_OFS_REQ: n.rdata[`PCR_EQ_W*N_CH-1:0] = lnk.eqctrl_out;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // settings stay frozen while an order is in flight
    if (access && pwrite && q.st == PCR_H_IDLE) begin
      case (paddr)
        `PCR_OFS_CTRL: begin
          // one order at a time; write wins if both bits are set
          if (pwdata[`PCR_CTRL_WR_BIT]) begin
            n.st = PCR_H_PEND;
            n.op = PCR_OP_WR;
          end else if (pwdata[`PCR_CTRL_RD_BIT]) begin
            n.st = PCR_H_PEND;
            n.op = PCR_OP_RD;
          end
        end
        `PCR_OFS_DIR: n.dir = pwdata[1:0];
        `PCR_OFS_WVOD: n.vod = pwdata[VW-1:0];
        `PCR_OFS_WPRE: n.pre = pwdata[PW-1:0];
        `PCR_OFS_WDCG: n.dcg = pwdata[DW-1:0];
        `PCR_OFS_WEQ: n.eq = pwdata[EW-1:0];
        default: n.st = q.st;
      endcase
    end
    case (q.st)
      PCR_H_IDLE: n.st = n.st;
      PCR_H_PEND: if (!lnk.busy) n.st = PCR_H_ISSUE;
      PCR_H_ISSUE: n.st = PCR_H_WAIT;
      PCR_H_WAIT: if (!lnk.busy) n.st = PCR_H_IDLE;
      default: n.st = PCR_H_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.dir <= `PCR_DIR_RST;
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = q.err;
  assign lnk.write_all = q.st == PCR_H_ISSUE && q.op == PCR_OP_WR;
  assign lnk.read = q.st == PCR_H_ISSUE && q.op == PCR_OP_RD;
  assign lnk.dir_sel = q.dir;
  assign lnk.vod = q.vod;
  assign lnk.preemp = q.pre;
  assign lnk.dcgain = q.dcg;
  assign lnk.eqctrl = q.eq;

endmodule

// ### rtl/pcr_dev_end.sv
/*
  controller end: walks every attached channel to write or read its
  drive level, pre-emphasis, dc gain and equalizer settings.
  assumes a requester on the same link and clock that keeps its side
  of the handshake; channel-side outputs hold the applied settings.
*/
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_dev_end
  import pcr_pkg::*;
#(
  parameter int N_CH = `PCR_N_CH,
  parameter bit SHARED = 1'b1,
  parameter int STEP_CYCLES = `PCR_STEP_CYCLES
) (
  input wire logic pclk, // 200 MHz clock
  input wire logic presetn, // async reset, active low
  pcr_link_if.dev lnk, // link from the requester
  output logic [`PCR_VOD_W*N_CH-1:0] ch_vod, // applied drive levels
  output logic [`PCR_PRE_W*N_CH-1:0] ch_preemp, // applied pre-emphasis
  output logic [`PCR_DCG_W*N_CH-1:0] ch_dcgain, // applied dc gain
  output logic [`PCR_EQ_W*N_CH-1:0] ch_eqctrl, // applied equalizer
  output logic ch_update // pulse as one channel is served
);

  // shared option narrows the write inputs to one channel's worth
  localparam int M = SHARED ? 1 : N_CH;
  localparam int VN = `PCR_VOD_W * N_CH;
  localparam int PN = `PCR_PRE_W * N_CH;
  localparam int DN = `PCR_DCG_W * N_CH;
  localparam int EN = `PCR_EQ_W * N_CH;
  localparam int CW = N_CH > 1 ? $clog2(N_CH) : 1;
  localparam int SW = STEP_CYCLES > 1 ? $clog2(STEP_CYCLES) : 1;

  initial begin
    if (N_CH < 1 || N_CH > 64) begin
      $error("pcr_dev_end: N_CH must be 1 to 64");
    end
    if (STEP_CYCLES < 1 || STEP_CYCLES > 256) begin
      $error("pcr_dev_end: STEP_CYCLES must be 1 to 256");
    end
    // link write inputs must be one channel wide when shared
    if ($bits(lnk.vod) != `PCR_VOD_W * M) begin
      $error("pcr_dev_end: link write width does not match SHARED");
    end
  end

  typedef struct packed {
    pcr_dev_st_t st;
    logic [CW-1:0] ch;
    logic [SW-1:0] step;
    logic [1:0] dir;
    logic busy;
    logic dv;
    logic upd;
    logic [VN-1:0] w_vod;
    logic [PN-1:0] w_pre;
    logic [DN-1:0] w_dcg;
    logic [EN-1:0] w_eq;
    logic [VN-1:0] a_vod;
    logic [PN-1:0] a_pre;
    logic [DN-1:0] a_dcg;
    logic [EN-1:0] a_eq;
    logic [VN-1:0] r_vod;
    logic [PN-1:0] r_pre;
    logic [DN-1:0] r_dcg;
    logic [EN-1:0] r_eq;
  } pcr_dev_state_t;

  pcr_dev_state_t q, n;

  // low bit of channel c's field in an input of width w per channel
  function automatic int src_lsb(input int c, input int w);
    return SHARED ? 0 : c * w;
  endfunction

  // low bit of channel c's field in a per-channel concatenation
  function automatic int ch_lsb(input logic [CW-1:0] c, input int w);
    return int'(c) * w;
  endfunction

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    logic last_step;
    logic last_ch;
    logic tx_en;
    logic rx_en;
    int lv;
    int lp;
    int ld;
    int le;
    last_step = q.step == SW'(STEP_CYCLES - 1);
    last_ch = q.ch == CW'(N_CH - 1);
    // unlisted codes act as full duplex
    tx_en = q.dir != `PCR_DIR_RX_ONLY;
    rx_en = q.dir != `PCR_DIR_TX_ONLY;
    lv = ch_lsb(q.ch, `PCR_VOD_W);
    lp = ch_lsb(q.ch, `PCR_PRE_W);
    ld = ch_lsb(q.ch, `PCR_DCG_W);
    le = ch_lsb(q.ch, `PCR_EQ_W);
    n = q;
    n.upd = 1'b0;
    case (q.st)
      PCR_IDLE: begin
        if (lnk.write_all || lnk.read) begin
          n.st = lnk.write_all ? PCR_WRITE : PCR_READ;
          n.busy = 1'b1;
          n.dv = 1'b0;
          n.ch = '0;
          n.step = '0;
          n.dir = lnk.dir_sel;
        end
        // snapshot inputs; shared value spread over every channel
        if (lnk.write_all) begin
          for (int c = 0; c < N_CH; c++) begin
            n.w_vod[c*`PCR_VOD_W +: `PCR_VOD_W] =
              lnk.vod[src_lsb(c, `PCR_VOD_W) +: `PCR_VOD_W];
            n.w_pre[c*`PCR_PRE_W +: `PCR_PRE_W] =
              lnk.preemp[src_lsb(c, `PCR_PRE_W) +: `PCR_PRE_W];
            n.w_dcg[c*`PCR_DCG_W +: `PCR_DCG_W] =
              lnk.dcgain[src_lsb(c, `PCR_DCG_W) +: `PCR_DCG_W];
            n.w_eq[c*`PCR_EQ_W +: `PCR_EQ_W] =
              lnk.eqctrl[src_lsb(c, `PCR_EQ_W) +: `PCR_EQ_W];
          end
        end
      end
      // requests are not looked at in these states
      PCR_WRITE, PCR_READ: begin
        n.step = q.step + SW'(1);
        if (last_step) begin
          n.step = '0;
          n.upd = 1'b1;
          if (q.st == PCR_WRITE && tx_en) begin
            n.a_vod[lv +: `PCR_VOD_W] = q.w_vod[lv +: `PCR_VOD_W];
            n.a_pre[lp +: `PCR_PRE_W] = q.w_pre[lp +: `PCR_PRE_W];
          end
          if (q.st == PCR_WRITE && rx_en) begin
            n.a_dcg[ld +: `PCR_DCG_W] = q.w_dcg[ld +: `PCR_DCG_W];
            n.a_eq[le +: `PCR_EQ_W] = q.w_eq[le +: `PCR_EQ_W];
          end
          // fetch the channel's current settings into read-back
          if (q.st == PCR_READ && tx_en) begin
            n.r_vod[lv +: `PCR_VOD_W] = q.a_vod[lv +: `PCR_VOD_W];
            n.r_pre[lp +: `PCR_PRE_W] = q.a_pre[lp +: `PCR_PRE_W];
          end
          if (q.st == PCR_READ && rx_en) begin
            n.r_dcg[ld +: `PCR_DCG_W] = q.a_dcg[ld +: `PCR_DCG_W];
            n.r_eq[le +: `PCR_EQ_W] = q.a_eq[le +: `PCR_EQ_W];
          end
          if (last_ch) begin
            n.st = PCR_IDLE;
            n.busy = 1'b0;
            n.dv = q.st == PCR_READ;
          end else begin
            n.ch = q.ch + CW'(1);
          end
        end
      end
      default: begin
        n.st = PCR_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign lnk.busy = q.busy;
  assign lnk.data_valid = q.dv;
  assign lnk.vod_out = q.r_vod;
  assign lnk.preemp_out = q.r_pre;
  assign lnk.dcgain_out = q.r_dcg;
  assign lnk.eqctrl_out = q.r_eq;
  assign ch_vod = q.a_vod;
  assign ch_preemp = q.a_pre;
  assign ch_dcgain = q.a_dcg;
  assign ch_eqctrl = q.a_eq;
  assign ch_update = q.upd;

endmodule

// ### verif/pcr_chk_sva.sv
/*
  link checker for the reconfiguration controller and its requester.
  assumes one clock, async active-low reset, and the same N_CH and
  STEP_CYCLES as the controller end it watches.
*/
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_chk #(
  parameter int N_CH = `PCR_N_CH,
  parameter int STEP_CYCLES = `PCR_STEP_CYCLES
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic write_all, // write order
  input wire logic read, // read order
  input wire logic busy, // controller busy
  input wire logic data_valid, // read-back valid
  input wire logic [`PCR_VOD_W*N_CH-1:0] vod_out // drive level read-back
);
  localparam int LAT = N_CH * STEP_CYCLES;
  localparam int LATP = LAT + 1;
  logic acc;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  assign acc = (write_all | read) & ~busy;

  //////////////////////////////////////////////////////////////////////
  chk_busy_rise: assert property (acc |=> busy)
    else $error("busy did not rise after an order");
  chk_busy_span: assert property (acc |-> ##LAT busy ##1 !busy)
    else $error("busy length differs from channel walk");
  chk_busy_len: assert property ($fell(busy) |->
    $past(busy, LAT) && !$past(busy, LATP))
    else $error("busy stretched by an order while busy");
  chk_rd_valid: assert property (acc && !write_all |->
    ##LATP !busy && data_valid)
    else $error("read end without data valid");
  chk_wr_novalid: assert property (acc && write_all |->
    ##LATP !data_valid)
    else $error("data valid after a write");
  chk_dv_clear: assert property (acc |-> ##[1:2] !data_valid)
    else $error("data valid kept after new order");
  chk_dv_hold: assert property ($fell(data_valid) |->
    $past(busy) || $past(write_all || read))
    else $error("data valid dropped with no order");
  chk_rb_hold: assert property ($changed(vod_out) |-> $past(busy))
    else $error("read-back changed outside a transfer");
  chk_pulse_wr: assert property (write_all |=> !write_all)
    else $error("write order longer than one cycle");
  chk_pulse_rd: assert property (read |=> !read)
    else $error("read order longer than one cycle");
  chk_one_op: assert property (!(write_all && read))
    else $error("write and read ordered together");
  chk_req_idle: assert property (write_all || read |-> !busy)
    else $error("order issued while busy");
endmodule

// ### verif/tb_top.sv
/*
  testbench: requester and controller ends joined by the link, driven
  over apb. assumes shared option, two channels, short channel step.
*/
`timescale 1ns/1ps
`include "pcr_regs.svh"

module tb_top;
  import pcr_pkg::*;
  localparam int N = 2;
  localparam int ST = 2;
  localparam logic [2:0] V1 = 3'h5, V2 = 3'h3, V3 = 3'h6;
  localparam logic [4:0] P1 = 5'h1A, P2 = 5'h07, P3 = 5'h11;
  localparam logic [1:0] D1 = 2'h2, D2 = 2'h1, D3 = 2'h3;
  localparam logic [3:0] E1 = 4'h9, E2 = 4'h6, E3 = 4'hC;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3*N-1:0] ch_vod;
  logic [5*N-1:0] ch_preemp;
  logic [2*N-1:0] ch_dcgain;
  logic [4*N-1:0] ch_eqctrl;
  logic ch_update;
  int n_mismatch, comparisons, cyc, n_upd, u0;

  pcr_link_if #(.N_CH(N), .SHARED(1'b1)) lnk ();
  pcr_req_end #(.N_CH(N), .SHARED(1'b1)) i_pcr_req_end (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  pcr_dev_end #(.N_CH(N), .SHARED(1'b1), .STEP_CYCLES(ST)) i_pcr_dev_end (
    .pclk(pclk), .presetn(presetn), .lnk(lnk), .ch_vod(ch_vod),
    .ch_preemp(ch_preemp), .ch_dcgain(ch_dcgain), .ch_eqctrl(ch_eqctrl),
    .ch_update(ch_update));
  pcr_chk #(.N_CH(N), .STEP_CYCLES(ST)) i_pcr_chk (.pclk(pclk),
    .presetn(presetn), .write_all(lnk.write_all), .read(lnk.read),
    .busy(lnk.busy), .data_valid(lnk.data_valid), .vod_out(lnk.vod_out));

  //////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (ch_update === 1'b1) n_upd++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, e, input string m);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %0t %s: saw %h want %h", $time, m, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll status until neither busy nor pending
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, `PCR_OFS_STAT, 32'h0);
      k++;
    end while ((rd[0] !== 1'b0 || rd[2] !== 1'b0) && k < 100);
    chk(32'(rd[2:0] & 3'h5), 32'h0, "idle in time");
  endtask

  task automatic order(input logic [2:0] v, input logic [4:0] p,
    input logic [1:0] g, input logic [3:0] e, input logic [1:0] dsel);
    apb(1'b1, `PCR_OFS_WVOD, 32'(v));
    apb(1'b1, `PCR_OFS_WPRE, 32'(p));
    apb(1'b1, `PCR_OFS_WDCG, 32'(g));
    apb(1'b1, `PCR_OFS_WEQ, 32'(e));
    apb(1'b1, `PCR_OFS_DIR, 32'(dsel));
    u0 = n_upd;
    apb(1'b1, `PCR_OFS_CTRL, 32'h1);
    wait_idle();
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PCR_OFS_STAT, 32'h0);
    chk(rd, 32'h0, "status after reset");
    apb(1'b0, `PCR_OFS_DIR, 32'h0);
    chk(rd, 32'h3, "direction after reset");
    chk(32'(ch_vod), 32'h0, "drive level after reset");
    $display("test reset done");
  endtask

  task automatic t_write();
    order(V1, P1, D1, E1, 2'h3);
    chk(32'(ch_vod), 32'({N{V1}}), "drive level broadcast");
    chk(32'(ch_preemp), 32'({N{P1}}), "pre-emphasis broadcast");
    chk(32'(ch_dcgain), 32'({N{D1}}), "dc gain broadcast");
    chk(32'(ch_eqctrl), 32'({N{E1}}), "equalizer broadcast");
    chk(32'(n_upd - u0), 32'(N), "channels served");
    chk(rd, 32'h0, "status after write");
    $display("test write done");
  endtask

  task automatic t_dir();
    order(V2, P2, D2, E2, 2'h2);
    chk(32'(ch_vod), 32'({N{V2}}), "tx only drive level");
    chk(32'(ch_dcgain), 32'({N{D1}}), "tx only keeps dc gain");
    order(V3, P3, D3, E3, 2'h1);
    chk(32'(ch_preemp), 32'({N{P2}}), "rx only keeps tx");
    chk(32'(ch_eqctrl), 32'({N{E3}}), "rx only equalizer");
    $display("test direction done");
  endtask

  task automatic t_read();
    apb(1'b1, `PCR_OFS_DIR, 32'h3);
    apb(1'b1, `PCR_OFS_CTRL, 32'h2);
    apb(1'b1, `PCR_OFS_WVOD, 32'h7);
    wait_idle();
    chk(rd, 32'h2, "status after read");
    apb(1'b0, `PCR_OFS_WVOD, 32'h0);
    chk(rd, 32'(V3), "write while busy ignored");
    apb(1'b0, `PCR_OFS_RVOD, 32'h0);
    chk(rd, 32'({N{V2}}), "drive level read-back");
    apb(1'b0, `PCR_OFS_RPRE, 32'h0);
    chk(rd, 32'({N{P2}}), "pre-emphasis read-back");
    apb(1'b0, `PCR_OFS_RDCG, 32'h0);
    chk(rd, 32'({N{D3}}), "dc gain read-back");
    apb(1'b0, `PCR_OFS_REQ, 32'h0);
    chk(rd, 32'({N{E3}}), "equalizer read-back");
    order(V1, P1, D1, E1, 2'h3);
    chk(rd, 32'h0, "valid cleared by write");
    $display("test read done");
  endtask

  task automatic t_err();
    apb(1'b0, 12'h02C, 32'h0);
    chk(32'(err), 32'h1, "unmapped address");
    apb(1'b1, 12'h006, 32'h1);
    chk(32'(err), 32'h1, "unaligned address");
    apb(1'b1, `PCR_OFS_RVOD, 32'h0);
    apb(1'b0, `PCR_OFS_RVOD, 32'h0);
    chk(rd, 32'({N{V2}}), "read-only kept");
    $display("test errors done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    t_reset();
    t_write();
    t_dir();
    t_read();
    t_err();
    t_reset();
    complete_run();
  end
endmodule
